// ---- inc/cmx_cfg.svh ----
// Constants for the miscellaneous-instruction execute block: timing, opcodes,
// instruction fields, register offsets, field positions and reset values.
// Assumes inclusion by bare name from the files of this block only.
`ifndef CMX_CFG_SVH
`define CMX_CFG_SVH

// ==========================================================================
// Timing
`define CMX_CLK_NS 50
`define CMX_TCY_NS 200
`define CMX_PHASES (`CMX_TCY_NS / `CMX_CLK_NS)
`define CMX_PH_LAST 2'h3
`define CMX_PH_FETCH 2'h0
`define CMX_PH_COMMIT 2'h1

// ==========================================================================
// Instruction word fields
`define CMX_OPC_HI 13
`define CMX_OPC_LO 8
`define CMX_DEST_BIT 7
`define CMX_ADDR_HI 6
`define CMX_ADDR_LO 0

// ==========================================================================
// Opcodes (upper six bits) and whole-word codes of operand-free instructions
`define CMX_OPC_FCLR 6'h01
`define CMX_OPC_FDEC 6'h03
`define CMX_OPC_FCOM 6'h09
`define CMX_OPC_DECSZ 6'h0b
`define CMX_INS_WDCLR 14'h0064
`define CMX_INS_ACALL 14'h000a
`define CMX_INS_ACLR 14'h0100

// ==========================================================================
// Register offsets (byte addresses, one word each)
`define CMX_OFS_CTRL 8'h00
`define CMX_OFS_ACC 8'h04
`define CMX_OFS_PCHI 8'h08
`define CMX_OFS_PC 8'h0c
`define CMX_OFS_STATUS 8'h10
`define CMX_OFS_STKTOP 8'h14

// ==========================================================================
// Field positions and reset values
`define CMX_CTRL_RUN 0
`define CMX_ST_ZERO 0
`define CMX_ST_PWDN 3
`define CMX_ST_TMO 4
`define CMX_RST_ACC 8'h00
`define CMX_RST_PCHI 7'h00
`define CMX_RST_PC 15'h0000
`define CMX_RST_RUN 1'b0
`define CMX_RST_FLAG 1'b1

`endif

// ---- inc/cmx_pkg.sv ----
// Types shared by the miscellaneous-instruction execute block.
// Assumes cmx_cfg.svh supplies the numeric constants.
package cmx_pkg;

	// ==================================================================
	// Sequencer states
	typedef enum logic [0:0] {
		CMX_ST_RUN = 1'b0,
		CMX_ST_FLUSH = 1'b1
	} cmx_state_t;

	typedef logic [7:0] cmx_byte_t;
	typedef logic [14:0] cmx_pc_t;

endpackage : cmx_pkg

// ---- src/cmx_file_mem.sv ----
// File register memory: 128 bytes, one read port with registered data and
// one write port. Assumes the caller orders reads and writes itself.
`timescale 1ns/100ps

module cmx_file_mem
	import cmx_pkg::*;
(
	input wire logic mclk_i,
	input wire logic [6:0] raddr_i,
	output cmx_byte_t rdata_o,
	input wire logic we_i,
	input wire logic [6:0] waddr_i,
	input cmx_byte_t wdata_i
);

	cmx_byte_t mem [0:127];
	cmx_byte_t rdata_reg;

	always_ff @(posedge mclk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_reg <= mem[raddr_i];
	end

	assign rdata_o = rdata_reg;

endmodule : cmx_file_mem

// ---- src/cmx_exec.sv ----
// Execute block for a group of miscellaneous instructions of an 8-bit core.
// Assumes an instruction source that offers one word per instruction cycle,
// an external watchdog and an external return stack fed by the push port.
//
// Overview of operation
// - Watchdog clear zeroes the watchdog counter.
// - Also zeroes prescaler, sets timeout and powerdown flags.
// - Accumulator call pushes program counter plus one.
// - Then loads accumulator and high latch into PC.
// - Accumulator call: two cycles, flags untouched.
// - Complement file, destination bit selects target, zero flag.
// - Clear file writes zero, sets zero flag.
// - Decrement file, destination bit selects target, zero flag.
// - Clear accumulator writes zero, sets zero flag.
// - Decrement-skip routes result, leaves flags alone.
// - Zero result discards next instruction as no-op.
`timescale 1ns/100ps
`include "cmx_cfg.svh"

module cmx_exec
	import cmx_pkg::*;
(
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic [13:0] instr_i,
	input wire logic instr_valid_i,
	output logic instr_ready_o,
	output logic instr_discard_o,
	output cmx_pc_t pc_o,
	output cmx_byte_t working_accumulator_o,
	output logic zero_flag_o,
	output logic timeout_flag_o,
	output logic powerdown_flag_o,
	input wire logic timeout_clear_i,
	input wire logic powerdown_clear_i,
	output logic watchdog_clear_o,
	output logic prescaler_clear_o,
	output logic stack_push_o,
	output cmx_pc_t stack_push_data_o,
	input wire logic [7:0] bus_addr_i,
	input wire logic [31:0] bus_wdata_i,
	input wire logic bus_wr_i,
	input wire logic bus_rd_i,
	output logic [31:0] bus_rdata_o
);

	// ==================================================================
	// Instruction-cycle phase divider
	// Each instruction cycle spans a fixed number of clocks; the phase
	// counter yields the one-cycle fetch and commit enables.
	logic [1:0] phase_reg;
	logic [1:0] phase_next;
	wire fetch_en;
	wire commit_en;

	assign phase_next = (phase_reg == `CMX_PH_LAST) ? 2'h0 : phase_reg + 2'h1;
	assign fetch_en = (phase_reg == `CMX_PH_FETCH);
	assign commit_en = (phase_reg == `CMX_PH_COMMIT);

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			phase_reg <= 2'h0;
		end else begin
			phase_reg <= phase_next;
		end
	end

	// ==================================================================
	// State
	cmx_state_t state_reg;
	cmx_state_t state_next;
	logic [13:0] ir_reg;
	logic ir_valid_reg;
	logic run_reg;
	cmx_byte_t acc_reg;
	cmx_byte_t acc_next;
	logic [6:0] pchi_reg;
	cmx_pc_t pc_reg;
	cmx_pc_t pc_next;
	logic zero_reg;
	logic zero_next;
	logic tmo_reg;
	logic pwdn_reg;
	logic wdclr_reg;
	logic push_reg;
	cmx_pc_t push_data_reg;
	logic discard_reg;
	logic [31:0] rdata_reg;

	// ==================================================================
	// Instruction intake
	// In the flush state the word offered is taken and dropped, so the
	// source never stalls on a skip or a call.
	wire take_instr;
	wire take_exec;
	wire take_drop;

	assign take_instr = fetch_en & instr_valid_i & run_reg;
	assign take_exec = take_instr & (state_reg == CMX_ST_RUN);
	assign take_drop = take_instr & (state_reg == CMX_ST_FLUSH);
	assign instr_ready_o = fetch_en & run_reg;

	// ==================================================================
	// Decode
	wire [5:0] opc;
	wire dest_file;
	wire [6:0] faddr;
	wire is_wdclr;
	wire is_acc_call;
	wire is_acc_clr;
	wire is_file_clr;
	wire is_file_com;
	wire is_file_dec;
	wire is_decsz;
	wire is_arith;

	assign opc = ir_reg[`CMX_OPC_HI:`CMX_OPC_LO];
	assign dest_file = ir_reg[`CMX_DEST_BIT];
	assign faddr = ir_reg[`CMX_ADDR_HI:`CMX_ADDR_LO];
	assign is_wdclr = (ir_reg == `CMX_INS_WDCLR);
	assign is_acc_call = (ir_reg == `CMX_INS_ACALL);
	assign is_acc_clr = (ir_reg == `CMX_INS_ACLR);
	assign is_file_clr = (opc == `CMX_OPC_FCLR) & ir_reg[`CMX_DEST_BIT];
	assign is_file_com = (opc == `CMX_OPC_FCOM);
	assign is_file_dec = (opc == `CMX_OPC_FDEC);
	assign is_decsz = (opc == `CMX_OPC_DECSZ);
	assign is_arith = is_file_com | is_file_dec | is_decsz;

	// ==================================================================
	// File register memory
	// The read address comes straight from the offered word so that the
	// registered read data stand in the commit phase.
	cmx_byte_t fdata;
	cmx_byte_t result;
	wire result_zero;
	wire exec_now;
	wire mem_we;

	cmx_file_mem i_cmx_file_mem (
		.mclk_i(mclk_i),
		.raddr_i(instr_i[`CMX_ADDR_HI:`CMX_ADDR_LO]),
		.rdata_o(fdata),
		.we_i(mem_we),
		.waddr_i(faddr),
		.wdata_i(result)
	);

	assign exec_now = commit_en & ir_valid_reg;

	always_comb begin
		result = 8'h00;
		if (is_file_com) begin
			result = ~fdata;
		end else if (is_file_dec | is_decsz) begin
			result = fdata - 8'h01;
		end
	end

	assign result_zero = (result == 8'h00);
	assign mem_we = exec_now & (is_file_clr | (is_arith & dest_file));

	wire skip_taken;
	wire second_cycle;

	assign skip_taken = is_decsz & result_zero;
	assign second_cycle = skip_taken | is_acc_call;

	// ==================================================================
	// Bus decode
	wire wr_ctrl;
	wire wr_acc;
	wire wr_pchi;
	wire wr_pc;

	assign wr_ctrl = bus_wr_i & (bus_addr_i == `CMX_OFS_CTRL);
	assign wr_acc = bus_wr_i & (bus_addr_i == `CMX_OFS_ACC);
	assign wr_pchi = bus_wr_i & (bus_addr_i == `CMX_OFS_PCHI);
	assign wr_pc = bus_wr_i & (bus_addr_i == `CMX_OFS_PC);

	// ==================================================================
	// Next-state logic
	// An instruction commit outranks a bus write landing in the same
	// clock; software should halt the core before editing its state.
	always_comb begin
		acc_next = acc_reg;
		if (exec_now & is_acc_clr) begin
			acc_next = 8'h00;
		end else if (exec_now & is_arith & !dest_file) begin
			acc_next = result;
		end else if (wr_acc) begin
			acc_next = bus_wdata_i[7:0];
		end
	end

	always_comb begin
		zero_next = zero_reg;
		if (exec_now & (is_acc_clr | is_file_clr)) begin
			zero_next = 1'b1;
		end else if (exec_now & (is_file_com | is_file_dec)) begin
			zero_next = result_zero;
		end
	end

	always_comb begin
		pc_next = pc_reg;
		if (exec_now & is_acc_call) begin
			pc_next = {pchi_reg, acc_reg};
		end else if (exec_now | (commit_en & discard_reg)) begin
			pc_next = pc_reg + 15'h0001;
		end else if (wr_pc) begin
			pc_next = bus_wdata_i[14:0];
		end
	end

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			CMX_ST_RUN: begin
				if (exec_now & second_cycle) begin
					state_next = CMX_ST_FLUSH;
				end
			end
			CMX_ST_FLUSH: begin
				if (commit_en & discard_reg) begin
					state_next = CMX_ST_RUN;
				end
			end
		endcase
	end

	// ==================================================================
	// Registers
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			state_reg <= CMX_ST_RUN;
			ir_reg <= 14'h0000;
			ir_valid_reg <= 1'b0;
			discard_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (fetch_en) begin
				ir_reg <= instr_i;
				ir_valid_reg <= take_exec;
				discard_reg <= take_drop;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			run_reg <= `CMX_RST_RUN;
			acc_reg <= `CMX_RST_ACC;
			pchi_reg <= `CMX_RST_PCHI;
			pc_reg <= `CMX_RST_PC;
			zero_reg <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				run_reg <= bus_wdata_i[`CMX_CTRL_RUN];
			end
			if (wr_pchi) begin
				pchi_reg <= bus_wdata_i[6:0];
			end
			acc_reg <= acc_next;
			pc_reg <= pc_next;
			zero_reg <= zero_next;
		end
	end

	// ==================================================================
	// Watchdog clear and status flags
	// A watchdog clear beats a same-cycle clear request from outside.
	wire wdclr_now;

	assign wdclr_now = exec_now & is_wdclr;

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			tmo_reg <= `CMX_RST_FLAG;
			pwdn_reg <= `CMX_RST_FLAG;
			wdclr_reg <= 1'b0;
		end else begin
			wdclr_reg <= wdclr_now;
			if (wdclr_now) begin
				tmo_reg <= 1'b1;
				pwdn_reg <= 1'b1;
			end else begin
				if (timeout_clear_i) begin
					tmo_reg <= 1'b0;
				end
				if (powerdown_clear_i) begin
					pwdn_reg <= 1'b0;
				end
			end
		end
	end

	// ==================================================================
	// Return stack push
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			push_reg <= 1'b0;
			push_data_reg <= 15'h0000;
		end else begin
			push_reg <= exec_now & is_acc_call;
			if (exec_now & is_acc_call) begin
				push_data_reg <= pc_reg + 15'h0001;
			end
		end
	end

	// ==================================================================
	// Register read port
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (bus_addr_i)
			`CMX_OFS_CTRL: rd_mux[`CMX_CTRL_RUN] = run_reg;
			`CMX_OFS_ACC: rd_mux[7:0] = acc_reg;
			`CMX_OFS_PCHI: rd_mux[6:0] = pchi_reg;
			`CMX_OFS_PC: rd_mux[14:0] = pc_reg;
			`CMX_OFS_STATUS: begin
				rd_mux[`CMX_ST_ZERO] = zero_reg;
				rd_mux[`CMX_ST_PWDN] = pwdn_reg;
				rd_mux[`CMX_ST_TMO] = tmo_reg;
			end
			`CMX_OFS_STKTOP: rd_mux[14:0] = push_data_reg;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			rdata_reg <= 32'h0000_0000;
		end else if (bus_rd_i) begin
			rdata_reg <= rd_mux;
		end else begin
			rdata_reg <= 32'h0000_0000;
		end
	end

	// ==================================================================
	// Outputs
	assign instr_discard_o = discard_reg;
	assign pc_o = pc_reg;
	assign working_accumulator_o = acc_reg;
	assign zero_flag_o = zero_reg;
	assign timeout_flag_o = tmo_reg;
	assign powerdown_flag_o = pwdn_reg;
	assign watchdog_clear_o = wdclr_reg;
	assign prescaler_clear_o = wdclr_reg;
	assign stack_push_o = push_reg;
	assign stack_push_data_o = push_data_reg;
	assign bus_rdata_o = rdata_reg;

endmodule : cmx_exec

// ---- tb/cmx_exec_checker.sv ----
// Checker for the execute block: timing and effects of the instruction group.
// Assumes commit one clock after a word is taken and pulses one clock later.
`timescale 1ns/100ps
`include "cmx_cfg.svh"

module cmx_exec_checker
	import cmx_pkg::*;
(
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic [13:0] instr_i,
	input wire logic instr_valid_i,
	input wire logic instr_ready_o,
	input wire logic instr_discard_o,
	input cmx_pc_t pc_o,
	input cmx_byte_t working_accumulator_o,
	input wire logic zero_flag_o,
	input wire logic timeout_flag_o,
	input wire logic powerdown_flag_o,
	input wire logic watchdog_clear_o,
	input wire logic prescaler_clear_o,
	input wire logic stack_push_o,
	input cmx_pc_t stack_push_data_o
);
	// ==================================================================
	// Decode of the word taken in this clock
	wire logic take_w = instr_ready_o && instr_valid_i;
	wire logic wd_t = take_w && instr_i == `CMX_INS_WDCLR;
	wire logic call_t = take_w && instr_i == `CMX_INS_ACALL;
	wire logic aclr_t = take_w && instr_i == `CMX_INS_ACLR;
	wire logic fclr_t = take_w && instr_i[13:7] == {`CMX_OPC_FCLR, 1'b1};
	wire logic dsz_t = take_w && instr_i[13:8] == `CMX_OPC_DECSZ;

	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	// ==================================================================
	// A dropped word shows discard in the clock after it is taken.
	wd_pulse_a: assert property (
		wd_t ##1 !instr_discard_o |-> ##1 watchdog_clear_o && prescaler_clear_o)
		else $error("watchdog clear pulse missing");
	pulse_cause_a: assert property (watchdog_clear_o |-> $past(wd_t, 2))
		else $error("watchdog clear pulse without cause");
	wd_flags_a: assert property (
		wd_t ##1 !instr_discard_o |-> ##1 timeout_flag_o && powerdown_flag_o)
		else $error("timeout or powerdown flag not set");
	call_push_a: assert property (
		call_t ##1 !instr_discard_o |-> ##1 stack_push_o
		&& stack_push_data_o == $past(pc_o, 2) + 15'h0001) else $error("bad return push");
	call_pc_a: assert property (
		call_t ##1 !instr_discard_o |-> ##1 pc_o[7:0] == $past(working_accumulator_o, 2))
		else $error("call target low byte wrong");
	call_flags_a: assert property (
		call_t ##1 !instr_discard_o |-> ##1 $stable(zero_flag_o))
		else $error("call changed zero flag");
	fclr_zero_a: assert property (fclr_t ##1 !instr_discard_o |-> ##1 zero_flag_o)
		else $error("clear file left zero flag low");
	aclr_zero_a: assert property (
		aclr_t ##1 !instr_discard_o |-> ##1 working_accumulator_o == 8'h00 && zero_flag_o)
		else $error("clear accumulator wrong");
	dsz_flags_a: assert property (
		dsz_t ##1 !instr_discard_o |-> ##1 $stable(zero_flag_o))
		else $error("decrement skip changed zero flag");
	disc_len_a: assert property (
		$rose(instr_discard_o) |-> instr_discard_o [*4] ##1 !instr_discard_o)
		else $error("discard window length wrong");
	ready_gap_a: assert property (instr_ready_o |=> !instr_ready_o [*3])
		else $error("instruction taken twice in one cycle");

	// Discard is raised at the next fetch edge and is first sampled one clock later.
	cover property (call_t ##1 !instr_discard_o ##4 instr_discard_o);
	cover property (dsz_t ##5 instr_discard_o);
	cover property (wd_t ##2 watchdog_clear_o);
endmodule : cmx_exec_checker

bind cmx_exec cmx_exec_checker i_cmx_exec_checker (.mclk_i(mclk_i), .resetn_i(resetn_i),
	.instr_i(instr_i), .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o),
	.instr_discard_o(instr_discard_o), .pc_o(pc_o),
	.working_accumulator_o(working_accumulator_o), .zero_flag_o(zero_flag_o),
	.timeout_flag_o(timeout_flag_o), .powerdown_flag_o(powerdown_flag_o),
	.watchdog_clear_o(watchdog_clear_o), .prescaler_clear_o(prescaler_clear_o),
	.stack_push_o(stack_push_o), .stack_push_data_o(stack_push_data_o));

// ---- tb/tb.sv ----
// Self-checking bench for the execute block: register port and instruction driver.
// Assumes the block alone; file memory is seen only through the accumulator, the zero flag and the skip discard.
`timescale 1ns/100ps
`include "cmx_cfg.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("[ERR] %s expected %0h seen %0h", n, e, g); end end

module tb
	import cmx_pkg::*;
;
	logic mclk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic instr_valid_i = 1'b0;
	logic [13:0] instr_i = 14'h0000;
	logic timeout_clear_i = 1'b0;
	logic powerdown_clear_i = 1'b0;
	logic [7:0] bus_addr_i = 8'h00;
	logic [31:0] bus_wdata_i = 32'h0000_0000;
	logic bus_wr_i = 1'b0;
	logic bus_rd_i = 1'b0;
	logic [31:0] bus_rdata_o;
	logic instr_ready_o, instr_discard_o, zero_flag_o, timeout_flag_o, powerdown_flag_o;
	logic watchdog_clear_o, prescaler_clear_o, stack_push_o;
	cmx_pc_t pc_o, stack_push_data_o, exp_pc, old_pc;
	cmx_byte_t working_accumulator_o;
	int fail_count = 0;
	int total_checks = 0;
	int wd_cnt = 0;
	int push_cnt = 0;
	int psc_cnt = 0;
	localparam logic [6:0] f_a = 7'h05;
	localparam logic [6:0] f_b = 7'h7f;

	cmx_exec i_cmx_exec (.mclk_i(mclk_i), .resetn_i(resetn_i), .instr_i(instr_i),
		.instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o),
		.instr_discard_o(instr_discard_o), .pc_o(pc_o),
		.working_accumulator_o(working_accumulator_o), .zero_flag_o(zero_flag_o),
		.timeout_flag_o(timeout_flag_o), .powerdown_flag_o(powerdown_flag_o),
		.timeout_clear_i(timeout_clear_i), .powerdown_clear_i(powerdown_clear_i),
		.watchdog_clear_o(watchdog_clear_o), .prescaler_clear_o(prescaler_clear_o),
		.stack_push_o(stack_push_o), .stack_push_data_o(stack_push_data_o),
		.bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i),
		.bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o));

	initial forever #25 mclk_i = ~mclk_i;

	// Pulses are counted mid-cycle so that the launching edge never races the count.
	always @(negedge mclk_i) begin
		wd_cnt += (watchdog_clear_o === 1'b1);
		psc_cnt += (prescaler_clear_o === 1'b1);
		push_cnt += (stack_push_o === 1'b1);
	end

	// ==================================================================
	// Drivers
	function automatic logic [13:0] fw(input logic [5:0] op, input logic d, input logic [6:0] f);
		return {op, d, f};
	endfunction : fw

	task automatic bwr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		bus_addr_i <= a;
		bus_wdata_i <= d;
		bus_wr_i <= 1'b1;
		@(posedge mclk_i);
		bus_wr_i <= 1'b0;
	endtask : bwr

	task automatic brd(input logic [7:0] a, input logic [31:0] e, input string n);
		@(posedge mclk_i);
		bus_addr_i <= a;
		bus_rd_i <= 1'b1;
		@(posedge mclk_i);
		bus_rd_i <= 1'b0;
		@(negedge mclk_i);
		`CHK(n, e, bus_rdata_o)
		@(negedge mclk_i);
		`CHK("rdata idle", 32'h0000_0000, bus_rdata_o)
	endtask : brd

	// Offers one word, then checks in phase 3, after commit and after the pulses.
	task automatic xw(input logic [13:0] w, input cmx_byte_t ew, input logic ez);
		int n;
		n = 0;
		@(posedge mclk_i);
		instr_i <= w;
		instr_valid_i <= 1'b1;
		@(negedge mclk_i);
		while (instr_ready_o !== 1'b1 && n < 8) begin
			@(negedge mclk_i);
			n++;
		end
		`CHK("ready", 1'b1, instr_ready_o)
		@(posedge mclk_i);
		instr_valid_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		@(negedge mclk_i);
		exp_pc = exp_pc + 15'h0001;
		`CHK("pc", exp_pc, pc_o)
		`CHK("acc", ew, working_accumulator_o)
		`CHK("zero", ez, zero_flag_o)
	endtask : xw

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : give_verdict

	// ==================================================================
	// Tests; the whole run needs under 150 clocks, so 5000 means a hang.
	initial begin
		repeat (5000) @(posedge mclk_i);
		fail_count++;
		give_verdict();
	end

	initial begin
		exp_pc = 15'h0000;
		repeat (10) @(posedge mclk_i);
		resetn_i <= 1'b1;
		@(posedge mclk_i);
		brd(`CMX_OFS_ACC, 32'h0000_0000, "acc");
		brd(`CMX_OFS_PC, 32'h0000_0000, "pc");
		bwr(`CMX_OFS_STATUS, 32'h0000_0000);
		brd(`CMX_OFS_STATUS, 32'h0000_0018, "status");
		brd(8'h20, 32'h0000_0000, "unmapped");
		bwr(`CMX_OFS_CTRL, 32'h0000_0001);
		$display("test reset done");
		xw(fw(`CMX_OPC_FCLR, 1'b1, f_a), 8'h00, 1'b1);
		xw(fw(`CMX_OPC_FDEC, 1'b1, f_a), 8'h00, 1'b0);
		xw(fw(`CMX_OPC_FDEC, 1'b0, f_a), 8'hfe, 1'b0);
		xw(fw(`CMX_OPC_FCOM, 1'b0, f_a), 8'h00, 1'b1);
		xw(fw(`CMX_OPC_FCOM, 1'b1, f_a), 8'h00, 1'b1);
		xw(fw(`CMX_OPC_FDEC, 1'b0, f_a), 8'hff, 1'b0);
		xw(fw(`CMX_OPC_FCLR, 1'b1, f_b), 8'hff, 1'b1);
		xw(fw(`CMX_OPC_FDEC, 1'b1, f_b), 8'hff, 1'b0);
		xw(fw(`CMX_OPC_FDEC, 1'b0, f_b), 8'hfe, 1'b0);
		xw(fw(`CMX_OPC_FCOM, 1'b0, f_a), 8'hff, 1'b0);
		xw(`CMX_INS_ACLR, 8'h00, 1'b1);
		$display("test file ops done");
		@(posedge mclk_i);
		timeout_clear_i <= 1'b1;
		powerdown_clear_i <= 1'b1;
		@(posedge mclk_i);
		timeout_clear_i <= 1'b0;
		powerdown_clear_i <= 1'b0;
		@(negedge mclk_i);
		`CHK("timeout", 1'b0, timeout_flag_o)
		`CHK("powerdown", 1'b0, powerdown_flag_o)
		xw(`CMX_INS_WDCLR, 8'h00, 1'b1);
		`CHK("timeout", 1'b1, timeout_flag_o)
		`CHK("powerdown", 1'b1, powerdown_flag_o)
		`CHK("wd pulses", 1, wd_cnt)
		`CHK("prescaler pulses", 1, psc_cnt)
		$display("test watchdog done");
		bwr(`CMX_OFS_ACC, 32'h0000_003c);
		bwr(`CMX_OFS_PCHI, 32'h0000_0012);
		old_pc = exp_pc;
		// The target is one above so that the common increment lands on it.
		exp_pc = 15'h123b;
		xw(`CMX_INS_ACALL, 8'h3c, 1'b1);
		`CHK("pushes", 1, push_cnt)
		`CHK("push data", old_pc + 15'h0001, stack_push_data_o)
		xw(fw(`CMX_OPC_FDEC, 1'b0, f_a), 8'h3c, 1'b1);
		`CHK("discard", 1'b1, instr_discard_o)
		brd(`CMX_OFS_STKTOP, {17'h0_0000, old_pc + 15'h0001}, "stack top");
		$display("test call done");
		xw(fw(`CMX_OPC_FCLR, 1'b1, f_a), 8'h3c, 1'b1);
		xw(fw(`CMX_OPC_FDEC, 1'b1, f_a), 8'h3c, 1'b0);
		xw(fw(`CMX_OPC_FDEC, 1'b1, f_a), 8'h3c, 1'b0);
		xw(fw(`CMX_OPC_FCOM, 1'b1, f_a), 8'h3c, 1'b0);
		xw(fw(`CMX_OPC_DECSZ, 1'b1, f_a), 8'h3c, 1'b0);
		xw(`CMX_INS_ACLR, 8'h3c, 1'b0);
		`CHK("discard", 1'b1, instr_discard_o)
		xw(fw(`CMX_OPC_FDEC, 1'b0, f_a), 8'hff, 1'b0);
		`CHK("discard", 1'b0, instr_discard_o)
		xw(fw(`CMX_OPC_DECSZ, 1'b0, f_a), 8'hff, 1'b0);
		xw(`CMX_INS_ACLR, 8'h00, 1'b1);
		xw(fw(`CMX_OPC_DECSZ, 1'b0, f_a), 8'hff, 1'b1);
		$display("test skip done");
		give_verdict();
	end
endmodule : tb
